// file: verilog/tcom_pkg.sv
// Constants shared by the timer compare output mode logic.
package tcom_pkg;

	//--------------------------------------------------------------
	// Register map
	//--------------------------------------------------------------
	localparam logic [15:0] TCOM_CH0_CTRL_ADDR  = 16'h2904;
	localparam logic [15:0] TCOM_CH1_CTRL_ADDR  = 16'h2906;
	localparam logic [15:0] TCOM_CH2_CTRL_ADDR  = 16'h2908;
	localparam logic [15:0] TCOM_CTRL_STRIDE    = 16'h0002;
	localparam int          TCOM_NUM_CH         = 3;

	//--------------------------------------------------------------
	// Control low byte fields
	//--------------------------------------------------------------
	localparam int          TCOM_MODE_MSB       = 7;
	localparam int          TCOM_MODE_LSB       = 5;
	localparam int          TCOM_PIN_STATE_BIT  = 3;
	localparam int          TCOM_LEVEL_BIT      = 2;
	localparam logic [7:0]  TCOM_LO_WR_MASK     = 8'hf7;

	//--------------------------------------------------------------
	// Control high byte fields
	//--------------------------------------------------------------
	localparam logic [7:0]  TCOM_HI_WR_MASK     = 8'hc5;

	//--------------------------------------------------------------
	// Reset values
	//--------------------------------------------------------------
	localparam logic [7:0]  TCOM_LO_RESET       = 8'h00;
	localparam logic [7:0]  TCOM_HI_RESET       = 8'h00;
	localparam logic        TCOM_PIN_RESET      = 1'b0;
	localparam logic [7:0]  TCOM_RDATA_RESET    = 8'h00;

	//--------------------------------------------------------------
	// Output modes
	//--------------------------------------------------------------
	localparam logic [2:0]  TCOM_MODE_LEVEL      = 3'h0;
	localparam logic [2:0]  TCOM_MODE_SET        = 3'h1;
	localparam logic [2:0]  TCOM_MODE_TOG_RESET  = 3'h2;
	localparam logic [2:0]  TCOM_MODE_SET_RESET  = 3'h3;
	localparam logic [2:0]  TCOM_MODE_TOGGLE     = 3'h4;
	localparam logic [2:0]  TCOM_MODE_RESET      = 3'h5;
	localparam logic [2:0]  TCOM_MODE_TOG_SET    = 3'h6;
	localparam logic [2:0]  TCOM_MODE_RESET_SET  = 3'h7;

	//--------------------------------------------------------------
	// Pin action applied at a match
	//--------------------------------------------------------------
	typedef enum logic [1:0] {
		TCOM_ACT_HOLD,
		TCOM_ACT_HIGH,
		TCOM_ACT_LOW,
		TCOM_ACT_INVERT
	} tcom_act_e;

endpackage

// file: verilog/tcom_compare_outputs.sv
// Three-channel timer compare output mode logic with its control registers.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps

module tcom_compare_outputs
	import tcom_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock, reset and enable
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_ce,
	// Timer interface
	input  wire logic             i_timer_clear,
	input  wire logic [CNT_W-1:0] i_timer_count_value,
	input  wire logic [CNT_W-1:0] i_period_compare_value,
	input  wire logic [CNT_W-1:0] i_channel_compare_value_1,
	input  wire logic [CNT_W-1:0] i_channel_compare_value_2,
	// Register port
	input  wire logic [15:0]      i_addr,
	input  wire logic [7:0]       i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output logic      [7:0]       o_rdata,
	// Pins
	output logic                  o_period_channel_pin,
	output logic      [1:0]       o_channel_output_pin
);

	//--------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------

	// Finds which channel a byte address belongs to, and whether it hits the map.
	function automatic logic [2:0] tcom_decode(input logic [15:0] addr);
		logic [15:0] off;
		logic [2:0]  res;
		off = addr - TCOM_CH0_CTRL_ADDR;
		res = 3'h0;
		if (addr >= TCOM_CH0_CTRL_ADDR &&
		    addr <= TCOM_CH2_CTRL_ADDR + TCOM_CTRL_STRIDE - 16'h0001) begin
			// Bit 2 flags a hit, bit 1 the channel MSB, bit 0 the channel LSB.
			res = {1'b1, 2'(off[15:1])};
		end
		return res;
	endfunction

	// Action a mode takes on a channel's own match.
	function automatic tcom_act_e tcom_own_act(input logic [2:0] mode, input logic is_ch0);
		tcom_act_e act;
		act = TCOM_ACT_HOLD;
		case (mode)
			TCOM_MODE_SET: begin
				act = TCOM_ACT_HIGH;
			end
			TCOM_MODE_TOG_RESET: begin
				act = is_ch0 ? TCOM_ACT_HOLD : TCOM_ACT_INVERT;
			end
			TCOM_MODE_SET_RESET: begin
				act = is_ch0 ? TCOM_ACT_HOLD : TCOM_ACT_HIGH;
			end
			TCOM_MODE_TOGGLE: begin
				act = TCOM_ACT_INVERT;
			end
			TCOM_MODE_RESET: begin
				act = TCOM_ACT_LOW;
			end
			TCOM_MODE_TOG_SET: begin
				act = is_ch0 ? TCOM_ACT_HOLD : TCOM_ACT_INVERT;
			end
			TCOM_MODE_RESET_SET: begin
				act = is_ch0 ? TCOM_ACT_HOLD : TCOM_ACT_LOW;
			end
			default: begin
				act = TCOM_ACT_HOLD;
			end
		endcase
		return act;
	endfunction

	// Action a mode takes on a channel-0 match, for channels 1 and 2.
	function automatic tcom_act_e tcom_period_act(input logic [2:0] mode);
		tcom_act_e act;
		act = TCOM_ACT_HOLD;
		case (mode)
			TCOM_MODE_TOG_RESET: begin
				act = TCOM_ACT_LOW;
			end
			TCOM_MODE_SET_RESET: begin
				act = TCOM_ACT_LOW;
			end
			TCOM_MODE_TOG_SET: begin
				act = TCOM_ACT_HIGH;
			end
			TCOM_MODE_RESET_SET: begin
				act = TCOM_ACT_HIGH;
			end
			default: begin
				act = TCOM_ACT_HOLD;
			end
		endcase
		return act;
	endfunction

	//--------------------------------------------------------------
	// Match detection
	//--------------------------------------------------------------

	// A match is taken once, at the edge where equality begins, so a
	// stalled count does not retoggle the pin every cycle.
	logic [CNT_W-1:0] cmp_val [TCOM_NUM_CH];
	logic [2:0]       eq_now;
	logic [2:0]       eq_prev_q;
	logic [2:0]       eq_prev_d;
	logic [2:0]       hit;

	assign cmp_val[0] = i_period_compare_value;
	assign cmp_val[1] = i_channel_compare_value_1;
	assign cmp_val[2] = i_channel_compare_value_2;

	genvar gi;
	generate
		for (gi = 0; gi < TCOM_NUM_CH; gi++) begin : g_eq
			assign eq_now[gi] = (i_timer_count_value == cmp_val[gi]);
		end
	endgenerate

	always_comb begin
		eq_prev_d = eq_prev_q;
		hit       = 3'h0;
		if (i_ce) begin
			eq_prev_d = eq_now;
			hit       = eq_now & ~eq_prev_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			eq_prev_q <= 3'h0;
		end else begin
			eq_prev_q <= eq_prev_d;
		end
	end

	//--------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------

	logic [7:0] ctrl_lo_q [TCOM_NUM_CH];
	logic [7:0] ctrl_lo_d [TCOM_NUM_CH];
	logic [7:0] ctrl_hi_q [TCOM_NUM_CH];
	logic [7:0] ctrl_hi_d [TCOM_NUM_CH];
	logic [2:0] wr_dec;
	logic [2:0] rd_dec;
	logic [2:0] mode [TCOM_NUM_CH];
	logic [2:0] pin_q;
	logic [2:0] pin_d;

	assign wr_dec = tcom_decode(i_addr);
	assign rd_dec = tcom_decode(i_addr);

	generate
		for (gi = 0; gi < TCOM_NUM_CH; gi++) begin : g_ctrl
			assign mode[gi] = ctrl_lo_q[gi][TCOM_MODE_MSB:TCOM_MODE_LSB];

			always_comb begin
				ctrl_lo_d[gi] = ctrl_lo_q[gi];
				ctrl_hi_d[gi] = ctrl_hi_q[gi];
				if (i_ce && i_wr && wr_dec[2] && wr_dec[1:0] == 2'(gi)) begin
					if (i_addr[0] == TCOM_CH0_CTRL_ADDR[0]) begin
						ctrl_lo_d[gi] = i_wdata & TCOM_LO_WR_MASK;
					end else begin
						ctrl_hi_d[gi] = i_wdata & TCOM_HI_WR_MASK;
					end
				end
			end

			always_ff @(posedge i_clk) begin
				if (i_reset) begin
					ctrl_lo_q[gi] <= TCOM_LO_RESET;
					ctrl_hi_q[gi] <= TCOM_HI_RESET;
				end else begin
					ctrl_lo_q[gi] <= ctrl_lo_d[gi];
					ctrl_hi_q[gi] <= ctrl_hi_d[gi];
				end
			end
		end
	endgenerate

	//--------------------------------------------------------------
	// Read port
	//--------------------------------------------------------------

	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [1:0] rd_ch;

	assign rd_ch = rd_dec[1:0];

	always_comb begin
		rdata_d = TCOM_RDATA_RESET;
		if (!i_ce) begin
			rdata_d = rdata_q;
		end else if (i_rd && rd_dec[2]) begin
			if (i_addr[0] == TCOM_CH0_CTRL_ADDR[0]) begin
				rdata_d = ctrl_lo_q[rd_ch];
				rdata_d[TCOM_PIN_STATE_BIT] = pin_q[rd_ch];
			end else begin
				rdata_d = ctrl_hi_q[rd_ch];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata_q <= TCOM_RDATA_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	//--------------------------------------------------------------
	// Output pins
	//--------------------------------------------------------------

	tcom_act_e act [TCOM_NUM_CH];

	generate
		for (gi = 0; gi < TCOM_NUM_CH; gi++) begin : g_pin
			always_comb begin
				act[gi] = TCOM_ACT_HOLD;
				if (gi != 0 && hit[0] && tcom_period_act(mode[gi]) != TCOM_ACT_HOLD) begin
					act[gi] = tcom_period_act(mode[gi]);
				end else if (hit[gi]) begin
					act[gi] = tcom_own_act(mode[gi], gi == 0);
				end
			end

			always_comb begin
				pin_d[gi] = pin_q[gi];
				if (i_ce) begin
					if (mode[gi] == TCOM_MODE_LEVEL) begin
						pin_d[gi] = ctrl_lo_q[gi][TCOM_LEVEL_BIT];
					end else if (i_timer_clear) begin
						pin_d[gi] = TCOM_PIN_RESET;
					end else begin
						case (act[gi])
							TCOM_ACT_HIGH: begin
								pin_d[gi] = 1'b1;
							end
							TCOM_ACT_LOW: begin
								pin_d[gi] = 1'b0;
							end
							TCOM_ACT_INVERT: begin
								pin_d[gi] = ~pin_q[gi];
							end
							default: begin
								pin_d[gi] = pin_q[gi];
							end
						endcase
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_q <= {TCOM_NUM_CH{TCOM_PIN_RESET}};
		end else begin
			pin_q <= pin_d;
		end
	end

	assign o_rdata              = rdata_q;
	assign o_period_channel_pin = pin_q[0];
	assign o_channel_output_pin = pin_q[2:1];

endmodule // tcom_compare_outputs

// file: tb/tcom_compare_outputs_asserts.sv
// Port-level assertions for the timer compare output logic.
`timescale 1ns/10ps

module tcom_chk #(
	parameter int CNT_W = 16
) (
	// Clock and control
	input wire logic             i_clk,
	input wire logic             i_reset,
	input wire logic             i_ce,
	input wire logic             i_timer_clear,
	input wire logic [CNT_W-1:0] i_timer_count_value,
	input wire logic [CNT_W-1:0] i_period_compare_value,
	input wire logic [CNT_W-1:0] i_channel_compare_value_1,
	input wire logic [CNT_W-1:0] i_channel_compare_value_2,
	// Register port and pins
	input wire logic [15:0]      i_addr,
	input wire logic [7:0]       i_wdata,
	input wire logic             i_wr,
	input wire logic             i_rd,
	input wire logic [7:0]       o_rdata,
	input wire logic             o_period_channel_pin,
	input wire logic [1:0]       o_channel_output_pin
);
	logic [2:0] md0_q, md1_q, md2_q, eq_q;
	logic       lv0_q;
	wire  [2:0] eq = {i_timer_count_value == i_channel_compare_value_2,
		i_timer_count_value == i_channel_compare_value_1,
		i_timer_count_value == i_period_compare_value};
	wire  [2:0] m  = eq & ~eq_q;
	wire        go = i_ce && !i_timer_clear;

	// Shadow of the mode fields and of the equality history.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			{md0_q, md1_q, md2_q, eq_q, lv0_q} <= '0;
		end else if (i_ce) begin
			eq_q <= eq;
			if (i_wr && i_addr == 16'h2904) begin
				md0_q <= i_wdata[7:5];
				lv0_q <= i_wdata[2];
			end
			if (i_wr && i_addr == 16'h2906) md1_q <= i_wdata[7:5];
			if (i_wr && i_addr == 16'h2908) md2_q <= i_wdata[7:5];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	property p_rd_idle; i_ce && !i_rd |=> o_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read");
	property p_unmap;
		i_ce && i_rd && (i_addr < 16'h2904 || i_addr > 16'h2909) |=> o_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_hi_rsvd; i_ce && i_rd && i_addr[0] |=> (o_rdata & 8'h3a) == 8'h00; endproperty
	a_hi_rsvd: assert property (p_hi_rsvd)
		else $error("reserved high bits not zero");
	property p_freeze;
		!i_ce |=> $stable(o_period_channel_pin) && $stable(o_channel_output_pin);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("pins moved while stalled");
	property p_level; i_ce && md0_q == 3'h0 |=> o_period_channel_pin == $past(lv0_q); endproperty
	a_level: assert property (p_level)
		else $error("pin does not follow level bit");
	property p_clear; i_ce && i_timer_clear && md0_q != 3'h0 |=> !o_period_channel_pin; endproperty
	a_clear: assert property (p_clear)
		else $error("timer clear left pin high");
	property p_tog0;
		go && m[0] && md0_q == 3'h4 |=> o_period_channel_pin != $past(o_period_channel_pin);
	endproperty
	a_tog0: assert property (p_tog0)
		else $error("channel 0 did not toggle");
	property p_rst0; go && m[0] && md0_q == 3'h5 |=> !o_period_channel_pin; endproperty
	a_rst0: assert property (p_rst0)
		else $error("channel 0 not driven low");
	property p_nomode0;
		go && md0_q inside {3'h2, 3'h3, 3'h6, 3'h7} |=> $stable(o_period_channel_pin);
	endproperty
	a_nomode0: assert property (p_nomode0)
		else $error("channel 0 moved in a dual mode");
	property p_setrst; go && m[0] && md1_q == 3'h3 |=> !o_channel_output_pin[0]; endproperty
	a_setrst: assert property (p_setrst)
		else $error("channel 1 not low on period match");
	property p_rstset;
		go && m[2] && !m[0] && md2_q == 3'h7 |=> !o_channel_output_pin[1];
	endproperty
	a_rstset: assert property (p_rstset)
		else $error("channel 2 not low on own match");
endmodule // tcom_chk

bind tcom_compare_outputs tcom_chk #(.CNT_W(CNT_W)) i_tcom_chk (.i_clk, .i_reset, .i_ce,
	.i_timer_clear, .i_timer_count_value, .i_period_compare_value,
	.i_channel_compare_value_1, .i_channel_compare_value_2, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .o_period_channel_pin, .o_channel_output_pin);

// file: tb/tb_top.sv
// Self-checking bench for the timer compare output logic.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_top;
	import tcom_pkg::*;
	logic        clk = 0, rst = 1, ce = 1, clr = 0, wr = 0, rd = 0;
	logic [15:0] cnt = 0, pv = 16'h0009, c1 = 16'h0005, c2 = 16'h0006, addr = 0;
	logic [7:0]  wd = 0, rdata;
	logic        p0;
	logic [1:0]  p12;
	int          mismatches = 0, total_checks = 0;

	always #5 clk = ~clk;

	tcom_compare_outputs #(.CNT_W(16)) i_tcom_compare_outputs (.i_clk(clk), .i_reset(rst),
		.i_ce(ce), .i_timer_clear(clr), .i_timer_count_value(cnt), .i_period_compare_value(pv),
		.i_channel_compare_value_1(c1), .i_channel_compare_value_2(c2), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_period_channel_pin(p0),
		.o_channel_output_pin(p12));

	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd8(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask

	task automatic wr_all(input logic [7:0] d);
		for (int i = 0; i < 3; i++) wr8(TCOM_CH0_CTRL_ADDR + 16'(2 * i), d);
	endtask

	task automatic hit(input logic [15:0] v);
		@(posedge clk);
		cnt <= v;
		@(posedge clk);
		cnt <= 16'h0000;
		#1;
	endtask

	task automatic t_regs();
		for (int a = 16'h2903; a <= 16'h290a; a++) rd8(16'(a), 8'h00);
		for (int i = 0; i < 6; i++) wr8(16'h2904 + 16'(i), 8'hff);
		for (int i = 0; i < 6; i += 2) rd8(16'h2904 + 16'(i), 8'hf7);
		for (int i = 1; i < 6; i += 2) rd8(16'h2904 + 16'(i), 8'hc5);
		wr8(16'h290a, 8'hff);
		rd8(16'h290a, 8'h00);
		for (int i = 0; i < 6; i++) wr8(16'h2904 + 16'(i), 8'h00);
	endtask

	task automatic t_level_set();
		wr8(16'h2904, 8'h04);
		@(posedge clk);
		#1 `CHK(p0, 1'b1)
		rd8(16'h2904, 8'h0c);
		wr8(16'h2906, 8'h20);
		hit(16'h0005);
		hit(16'h0009);
		`CHK(p12, 2'b01)
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		#1 `CHK({p0, p12}, 3'b100)
		wr8(16'h2904, 8'h00);
	endtask

	task automatic t_toggle_reset();
		wr_all(8'h80);
		hit(16'h0009);
		hit(16'h0005);
		hit(16'h0006);
		`CHK({p0, p12}, 3'b111)
		@(posedge clk);
		ce <= 1'b0;
		hit(16'h0009);
		@(posedge clk);
		ce <= 1'b1;
		#1 `CHK(p0, 1'b1)
		wr_all(8'ha0);
		hit(16'h0009);
		hit(16'h0005);
		hit(16'h0006);
		hit(16'h0009);
		`CHK({p0, p12}, 3'b000)
	endtask

	task automatic t_dual();
		logic [2:0] md [4] = '{3'h2, 3'h3, 3'h6, 3'h7};
		logic       eo [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
		logic       e0 [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 4; i++) begin
			wr_all({md[i], 5'h00});
			@(posedge clk);
			c1 <= 16'h0005;
			c2 <= 16'h0006;
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			hit(16'h0005);
			hit(16'h0006);
			`CHK({p0, p12}, {1'b0, {2{eo[i]}}})
			hit(16'h0009);
			`CHK({p0, p12}, {1'b0, {2{e0[i]}}})
			@(posedge clk);
			c1 <= 16'h0009;
			c2 <= 16'h0009;
			hit(16'h0009);
			`CHK({p0, p12}, {1'b0, {2{e0[i]}}})
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#50000;
		mismatches++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_level_set();
		t_toggle_reset();
		t_dual();
		print_verdict();
	end
endmodule // tb_top
